// ---- design/dci_pkg.sv ----
package dci_pkg;
   // Register byte offsets, per channel stride
   localparam logic [11:0] CTRL_BASE = 12'h000;
   localparam logic [11:0] STAT_BASE = 12'h040;
   localparam logic [11:0] CHAN_STRIDE = 12'h004;
   // Control field positions
   localparam int DELAY_LSB = 24;
   localparam int CTHR_LSB = 16;
   localparam int DTHR_LSB = 8;
   localparam int ERR_EN_BIT = 7;
   localparam int TMO_EN_BIT = 6;
   localparam int CMP_EN_BIT = 5;
   localparam int DRP_EN_BIT = 4;
   localparam int OTH_EN_BIT = 3;
   localparam int RUN_BIT = 0;
   // Reset values; THR_ZERO is the threshold write value that is ignored
   localparam logic [7:0] DELAY_RST = 8'h00;
   localparam logic [7:0] THR_RST = 8'h01;
   localparam logic [7:0] THR_ZERO = 8'h00;
   // Delay tick: one decrement per this many clocks
   localparam int TICK_CYCLES = 125;
   localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);
endpackage : dci_pkg

// ---- design/dci_ev_if.sv ----
`timescale 1ns/1ps
interface dci_ev_if;
   logic eop;
   logic new_pkt;
   logic [7:0] delay;
   logic tmo;
   modport ctl (output eop, output new_pkt, output delay, input tmo);
   modport tmr (input eop, input new_pkt, input delay, output tmo);
endinterface : dci_ev_if

// ---- design/dci_cnt.sv ----
`timescale 1ns/1ps
// Threshold down-counter: reloads after each hit or on a control write to its own channel
module dci_cnt (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic [7:0] thr_i,
   input wire logic load_i,
   input wire logic ev_i,
   output logic hit_o,
   output logic [7:0] cnt_o
);
   logic [7:0] cnt_q, cnt_d;
   always_comb
   begin
      cnt_d = cnt_q;
      hit_o = 1'b0;
      if (load_i)
      begin
         cnt_d = thr_i;
      end
      else if (ev_i)
      begin
         if (cnt_q <= 8'h01)
         begin
            hit_o = 1'b1;
            cnt_d = thr_i; // R20
         end
         else
         begin
            cnt_d = cnt_q - 8'h01;
         end
      end
   end
   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         cnt_q <= dci_pkg::THR_RST;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end
   assign cnt_o = cnt_q;
endmodule : dci_cnt

// ---- design/dci_channel_irq.sv ----
`timescale 1ns/1ps
// Overview of operation
// R01: One control register per channel
// R02: Bits 31:24 delay timeout, reset zero
// R03: Timer starts at packet end, restarts
// R04: Timer decrements once per 125 clocks
// R05: Timer runs on scatter-gather clock
// R06: Zero delay never times out
// R07: Completion threshold 23:16, interrupt at zero
// R08: Drop threshold 15:8, interrupt at zero
// R09: Threshold write of zero ignored
// R10: Bit 7 enables error interrupt
// R11: Bit 6 enables timeout interrupt
// R12: Bit 5 enables completion interrupt
// R13: Bit 4 enables drop interrupt
// R14: Bit 3 enables other-channel error interrupt
// R15: Bit 0 run bit starts fetching
// R16: Software never clears run bit; the code clears it on a control write with bit 0 low
// R17: Count completions only at end-of-frame
// R18: Status flags clear on write one
// R19: Interrupt is OR of enabled flags
// R20: Reserved bits zero; counters reload
////////////////////////////////////////////////////////////////////////////
module dci_channel_irq #(
   parameter int NUM_CH = 4
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [NUM_CH-1:0] cmp_ev_i,
   input wire logic [NUM_CH-1:0] cmp_eof_i,
   input wire logic [NUM_CH-1:0] drop_ev_i,
   input wire logic [NUM_CH-1:0] err_ev_i,
   input wire logic [NUM_CH-1:0] pkt_start_i,
   input wire logic [NUM_CH-1:0] pkt_end_i,
   output logic [NUM_CH-1:0] run_o,
   output logic [NUM_CH-1:0] irq_o
);
   // Status flag positions match the enables in the control word
   logic [31:0] ctrl_q [NUM_CH];
   logic [31:0] ctrl_d [NUM_CH];
   logic [7:0] flag_q [NUM_CH];
   logic [7:0] flag_d [NUM_CH];
   logic [7:0] ccnt [NUM_CH];
   logic [7:0] dcnt [NUM_CH];
   logic [NUM_CH-1:0] cmp_hit, drp_hit, tmo, wr_ctl, wr_sta;
   logic [NUM_CH-1:0] irq_d, any_err;
   logic [31:0] rd_d, rd_q;
   logic rdy_q, rdy_d, err_q, err_d, hit_any;
   logic setup;

   assign setup = psel_i && !penable_i;

   ////////////////////////////////////////////////////////////////////////
   for (genvar c = 0; c < NUM_CH; c++)
   begin : g_ch
      localparam logic [11:0] CA =
         12'(dci_pkg::CTRL_BASE + c * dci_pkg::CHAN_STRIDE);
      localparam logic [11:0] SA =
         12'(dci_pkg::STAT_BASE + c * dci_pkg::CHAN_STRIDE);
      dci_ev_if ev ();
      logic [31:0] w;
      // Writes commit only at the access edge
      assign wr_ctl[c] = psel_i && penable_i && pwrite_i && paddr_i == CA; // R01
      assign wr_sta[c] = psel_i && penable_i && pwrite_i && paddr_i == SA;
      assign w = pwdata_i;
      assign any_err[c] = err_ev_i[c];

      always_comb
      begin
         ctrl_d[c] = ctrl_q[c];
         if (wr_ctl[c])
         begin
            ctrl_d[c][31:24] = w[31:24]; // R02
            if (w[23:16] != dci_pkg::THR_ZERO) // R09
            begin
               ctrl_d[c][23:16] = w[23:16]; // R07
            end
            if (w[15:8] != dci_pkg::THR_ZERO) // R09
            begin
               ctrl_d[c][15:8] = w[15:8]; // R08
            end
            ctrl_d[c][7:3] = w[7:3]; // R10 R11 R12 R13 R14
            ctrl_d[c][2:1] = 2'h0; // R20
            ctrl_d[c][0] = w[0]; // R15
         end
      end

      // Other-channel errors: any error on a different channel
      always_comb
      begin
         flag_d[c] = flag_q[c];
         if (wr_sta[c])
         begin
            flag_d[c] = flag_q[c] & ~w[7:0]; // R18
         end
         // Sets placed after clears so a same-cycle event wins
         if (err_ev_i[c])
         begin
            flag_d[c][dci_pkg::ERR_EN_BIT] = 1'b1;
         end
         if (tmo[c])
         begin
            flag_d[c][dci_pkg::TMO_EN_BIT] = 1'b1;
         end
         if (cmp_hit[c])
         begin
            flag_d[c][dci_pkg::CMP_EN_BIT] = 1'b1;
         end
         if (drp_hit[c])
         begin
            flag_d[c][dci_pkg::DRP_EN_BIT] = 1'b1;
         end
         if ((any_err & ~(NUM_CH'(1) << c)) != '0) // R14
         begin
            flag_d[c][dci_pkg::OTH_EN_BIT] = 1'b1;
         end
         flag_d[c][2:0] = 3'h0;
      end

      assign irq_d[c] = |(flag_d[c][7:3] & ctrl_d[c][7:3]); // R19

      dci_cnt u_cmp (
         .core_clk_i(core_clk_i),
         .srst_i(srst_i),
         .thr_i(ctrl_q[c][23:16]),
         .load_i(wr_ctl[c]),
         .ev_i(cmp_ev_i[c] && cmp_eof_i[c]), // R17
         .hit_o(cmp_hit[c]),
         .cnt_o(ccnt[c])
      );
      dci_cnt u_drp (
         .core_clk_i(core_clk_i),
         .srst_i(srst_i),
         .thr_i(ctrl_q[c][15:8]),
         .load_i(wr_ctl[c]),
         .ev_i(drop_ev_i[c]),
         .hit_o(drp_hit[c]),
         .cnt_o(dcnt[c])
      );

      assign ev.eop = pkt_end_i[c];
      assign ev.new_pkt = pkt_start_i[c];
      assign ev.delay = ctrl_q[c][31:24];
      assign tmo[c] = ev.tmo;
      dci_tmr u_tmr (
         .core_clk_i(core_clk_i),
         .srst_i(srst_i),
         .ev(ev.tmr)
      );

      always_ff @(posedge core_clk_i)
      begin
         if (srst_i)
         begin
            ctrl_q[c] <= {dci_pkg::DELAY_RST, dci_pkg::THR_RST,
                          dci_pkg::THR_RST, 8'h00};
            flag_q[c] <= 8'h00;
         end
         else
         begin
            ctrl_q[c] <= ctrl_d[c];
            flag_q[c] <= flag_d[c];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Zero-wait slave: pready rises in the access cycle
   always_comb
   begin
      rd_d = 32'h0000_0000;
      hit_any = 1'b0;
      for (int i = 0; i < NUM_CH; i++)
      begin
         if (paddr_i == 12'(dci_pkg::CTRL_BASE + i * dci_pkg::CHAN_STRIDE))
         begin
            rd_d = ctrl_q[i];
            hit_any = 1'b1;
         end
         else if (paddr_i ==
                  12'(dci_pkg::STAT_BASE + i * dci_pkg::CHAN_STRIDE))
         begin
            rd_d = {dcnt[i] == 8'h00 ? 8'h00 : ctrl_q[i][31:24],
                    ccnt[i], dcnt[i], flag_q[i]};
            hit_any = 1'b1;
         end
      end
      rdy_d = setup;
      err_d = setup && !hit_any;
      if (!setup)
      begin
         rd_d = 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         rd_q <= 32'h0000_0000;
         rdy_q <= 1'b0;
         err_q <= 1'b0;
         irq_o <= '0;
         run_o <= '0;
      end
      else
      begin
         rd_q <= rd_d;
         rdy_q <= rdy_d;
         err_q <= err_d;
         irq_o <= irq_d;
         for (int i = 0; i < NUM_CH; i++)
         begin
            run_o[i] <= ctrl_d[i][dci_pkg::RUN_BIT]; // R15 R16
         end
      end
   end

   assign prdata_o = rd_q;
   assign pready_o = rdy_q;
   assign pslverr_o = err_q;
endmodule : dci_channel_irq

// ---- design/dci_tmr.sv ----
`timescale 1ns/1ps
// Delay timer on the scatter-gather clock (the only clock here)
module dci_tmr (
   input wire logic core_clk_i,
   input wire logic srst_i,
   dci_ev_if.tmr ev
);
   logic [6:0] pre_q, pre_d;
   logic [7:0] cnt_q, cnt_d;
   logic run_q, run_d;
   logic tmo_d;
   always_comb
   begin
      pre_d = pre_q;
      cnt_d = cnt_q;
      run_d = run_q;
      tmo_d = 1'b0;
      if (ev.new_pkt || ev.delay == 8'h00) // R03 R06
      begin
         run_d = 1'b0;
      end
      else if (ev.eop) // R03
      begin
         run_d = 1'b1;
         pre_d = 7'h00;
         cnt_d = ev.delay;
      end
      else if (run_q)
      begin
         if (pre_q == dci_pkg::TICK_LAST) // R04
         begin
            pre_d = 7'h00;
            if (cnt_q <= 8'h01)
            begin
               tmo_d = 1'b1;
               run_d = 1'b0; // R03
            end
            else
            begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         else
         begin
            pre_d = pre_q + 7'h01;
         end
      end
   end
   always_ff @(posedge core_clk_i) // R05
   begin
      if (srst_i)
      begin
         pre_q <= 7'h00;
         cnt_q <= 8'h00;
         run_q <= 1'b0;
      end
      else
      begin
         pre_q <= pre_d;
         cnt_q <= cnt_d;
         run_q <= run_d;
      end
   end
   assign ev.tmo = tmo_d;
endmodule : dci_tmr

// ---- bench/dci_channel_irq_props.sv ----
`timescale 1ns/1ps
module dci_channel_irq_props #(
   parameter int NUM_CH = 4
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [NUM_CH-1:0] run_o,
   input wire logic [NUM_CH-1:0] irq_o
);
   default clocking dcb @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);
   wire logic wr_acc = psel_i && penable_i && pwrite_i;
   ////////////////////////////////////////////////////////////////////////
   rdy_after_setup_a: assert property (
      psel_i && !penable_i |=> pready_o) else $error("no ready");
   rdy_single_a: assert property (
      pready_o |=> !pready_o) else $error("ready too long");
   rst_quiet_a: assert property (
      $fell(srst_i) |-> run_o == '0 && irq_o == '0) else $error("reset");
   run_wr_a: assert property (
      wr_acc && paddr_i == dci_pkg::CTRL_BASE |=>
      run_o[0] == $past(pwdata_i[0])) else $error("run not written");
   run_hold_a: assert property (
      !wr_acc |=> $stable(run_o)) else $error("run moved");
   irq_hold_a: assert property (
      irq_o[0] && !wr_acc |=> irq_o[0]) else $error("irq dropped");
   err_with_rdy_a: assert property (
      pslverr_o |-> pready_o) else $error("lone slverr");
   rdata_idle_a: assert property (
      !pready_o |-> prdata_o == '0) else $error("stray rdata");
   cover property ($rose(irq_o[0]));
   cover property ($rose(irq_o[3]));
   cover property (pslverr_o);
endmodule : dci_channel_irq_props
bind dci_channel_irq dci_channel_irq_props #(.NUM_CH(NUM_CH)) i_props (
   .core_clk_i(core_clk_i),
   .srst_i(srst_i),
   .psel_i(psel_i),
   .penable_i(penable_i),
   .pwrite_i(pwrite_i),
   .paddr_i(paddr_i),
   .pwdata_i(pwdata_i),
   .prdata_o(prdata_o),
   .pready_o(pready_o),
   .pslverr_o(pslverr_o),
   .run_o(run_o),
   .irq_o(irq_o)
);

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
   localparam logic [11:0] cb = dci_pkg::CTRL_BASE;
   localparam logic [11:0] sb = dci_pkg::STAT_BASE;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, prdy, perr, er;
   logic [11:0] pa = '0;
   logic [31:0] pwd = '0, prd, rd;
   logic [3:0] ce = 0, cf = 0, de = 0, ee = 0, ps = 0, pe = 0, run, irq;
   int n_fail = 0, checked = 0;
   dci_channel_irq i_dci_channel_irq (.core_clk_i(clk), .srst_i(rst),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
      .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
      .cmp_ev_i(ce), .cmp_eof_i(cf), .drop_ev_i(de), .err_ev_i(ee),
      .pkt_start_i(ps), .pkt_end_i(pe), .run_o(run), .irq_o(irq));
   initial forever #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("unexpected %s exp %h got %h", s, e, g);
      end
   endtask : chk
   // Waits for pready with no cycle limit; only the watchdog ends a hang
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1;
      do
      begin
         @(posedge clk);
      end
      while (prdy !== 1'b1);
      rd = prd;
      er = perr;
      chk("pready", 1, prdy);
      psel <= 0;
      pen <= 0;
      #1;
   endtask : apb
   // Event pulses last one cycle; result is settled on return
   task automatic ev(logic [3:0] c, f, d, r, s, e);
      @(posedge clk);
      ce <= c;
      cf <= f;
      de <= d;
      ee <= r;
      ps <= s;
      pe <= e;
      @(posedge clk);
      {ce, cf, de, ee, ps, pe} <= '0;
      #1;
   endtask : ev
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      apb(0, cb, 0);
      chk("ctrl0", 32'h00010100, rd);
      apb(0, sb, 0);
      chk("stat0", 32'h00010100, rd);
      chk("run", 0, run);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_ctrl;
      apb(1, cb + 12'h004, 32'hFFFFFFFE);
      apb(0, cb + 12'h004, 0);
      chk("ctrl1", 32'hFFFFFFF8, rd);
      apb(1, cb + 12'h004, 0);
      apb(0, cb + 12'h004, 0);
      chk("ctrl1", 32'h00FFFF00, rd);
      apb(0, cb, 0);
      chk("ctrl0", 32'h00010100, rd);
      apb(1, cb + 12'h008, 32'h00010101);
      chk("run", 32'h4, run);
      apb(0, 12'h0FC, 0);
      chk("slverr", 1, er);
      $display("t_ctrl done");
   endtask : t_ctrl
   // Control write reloads with the old threshold, so first hit is at once
   task automatic t_cmp;
      apb(1, cb, 32'h00030020);
      ev(1, 0, 0, 0, 0, 0);
      chk("irq", 0, irq);
      ev(1, 1, 0, 0, 0, 0);
      chk("irq", 1, irq);
      apb(1, sb, 32'h20);
      for (int i = 1; i <= 3; i++)
      begin
         ev(1, 1, 0, 0, 0, 0);
         chk("irq", i / 3, irq);
      end
      apb(1, sb, 0);
      chk("irq", 1, irq);
      apb(1, sb, 32'h20);
      chk("irq", 0, irq);
      $display("t_cmp done");
   endtask : t_cmp
   task automatic t_drop;
      apb(1, cb, 32'h00010010);
      ev(0, 0, 1, 0, 0, 0);
      chk("irq", 1, irq);
      apb(1, sb, 32'h10);
      chk("irq", 0, irq);
      $display("t_drop done");
   endtask : t_drop
   task automatic t_err;
      apb(1, cb, 32'h00010100);
      ev(0, 0, 0, 1, 0, 0);
      chk("irq", 0, irq);
      apb(1, cb, 32'h00010180);
      chk("irq", 1, irq);
      apb(1, sb, 32'h88);
      apb(1, cb, 32'h00010108);
      ev(0, 0, 0, 2, 0, 0);
      chk("irq", 1, irq);
      apb(1, sb, 32'h88);
      $display("t_err done");
   endtask : t_err
   task automatic t_tmo;
      apb(1, cb + 12'h00C, 32'h02010040);
      ev(0, 0, 0, 0, 0, 8);
      repeat (240) @(posedge clk);
      chk("irq", 0, irq);
      repeat (20) @(posedge clk);
      chk("irq", 8, irq);
      apb(1, sb + 12'h00C, 32'h40);
      apb(1, cb + 12'h00C, 32'h00010040);
      ev(0, 0, 0, 0, 0, 8);
      repeat (300) @(posedge clk);
      chk("irq", 0, irq);
      apb(1, cb + 12'h00C, 32'h01010040);
      ev(0, 0, 0, 0, 0, 8);
      repeat (100) @(posedge clk);
      ev(0, 0, 0, 0, 8, 0);
      repeat (100) @(posedge clk);
      chk("irq", 0, irq);
      $display("t_tmo done");
   endtask : t_tmo
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 0;
      t_reset;
      t_ctrl;
      t_cmp;
      t_drop;
      t_err;
      t_tmo;
      close_out;
   end
   // Tests need about 860 cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      n_fail++;
      close_out;
   end
endmodule : tb
